// >>> core/etc_pkg.sv
/*
 * constants and carrier types for the transmit control and status bank.
 * assumes a 200 MHz system clock and a MAC engine that raises one-cycle
 * event pulses, holds the deferring level and gives the config nibble in etc_mac_ev_t.
 */
package etc_pkg;
    // =================================================================
    // register map (byte addresses on a 32-bit APB)
    localparam int          CTL_IDX  = 3;
    localparam logic [11:0] CTL_ADDR = 12'(CTL_IDX * 4);
    localparam logic [11:0] IST_ADDR = 12'h010;
    localparam logic [11:0] IMR_ADDR = 12'h014;
    // =================================================================
    // transmit control field positions
    localparam int B_PGI  = 15;
    localparam int B_LTS  = 14;
    localparam int B_FCSI = 13;
    localparam int B_EXDS = 12;
    localparam int B_RSV1 = 11;
    localparam int B_XDF  = 10;
    localparam int B_DFR  = 9;
    localparam int B_NCAR = 8;
    localparam int B_CLST = 7;
    localparam int B_XCOL = 6;
    localparam int B_OWC  = 5;
    localparam int B_RSV0 = 4;
    localparam int B_MBAD = 3;
    localparam int B_UND  = 2;
    localparam int B_LMIS = 1;
    localparam int B_TOK  = 0;
    localparam logic [15:0] CTL_RST = 16'h0101;
    // =================================================================
    // interrupt status / mask fields
    localparam int IRQ_W     = 3;
    localparam int IRQ_PGI   = 0;
    localparam int IRQ_DONE  = 1;
    localparam int IRQ_ABORT = 2;
    // =================================================================
    // timing
    localparam real CLK_MHZ       = 200.0;
    localparam real DEFER_TIME_MS = 3.2;
    localparam real LATE_TIME_US  = 51.2;
    localparam int  DEFER_CYC     =
        int'($ceil(DEFER_TIME_MS * 1000.0 * CLK_MHZ));
    localparam int  LATE_CYC      =
        int'($ceil(LATE_TIME_US * CLK_MHZ));
    localparam int  COLL_MAX      = 16;
    // =================================================================
    // carriers
    typedef struct packed {
        logic       tx_start;
        logic [3:0] cfg_hi;
        logic       tx_end;
        logic       wb_done;
        logic       preamble;
        logic       sfd;
        logic       crs;
        logic       collision;
        logic       deferring;
        logic       first_defer;
        logic       crs_lost;
        logic       mon_bad;
        logic       underrun;
        logic       len_mismatch;
        logic       tx_ok;
    } etc_mac_ev_t;
    typedef struct packed {
        logic        valid;
        logic [15:0] status;
        logic [4:0]  coll;
    } etc_wb_t;
endpackage

// >>> core/etc_tx_ctrl.sv
/*
 * transmit control and status register bank with APB slave, sticky
 * interrupt status and the two transmit timers.
 * assumes the MAC raises single-cycle event pulses synchronous to
 * sys_clk_i and returns wb_done once the status word is in memory.
 */
// Implementation choice: the APB register port.
// Notes on behaviour
// RL1 - at transmission start load config bits 15..12 into the register
// RL2 - at transmission end set status bits 10..0 whose condition occurred
// RL3 - at end, write status and collision count to descriptor status
// RL4 - after descriptor write-back clear status bits 9 and 5
// RL5 - at next start clear bits 10, 7, 6, 1 and set bit 8
// RL6 - hardware reset sets bits 8 and 0, clears bit 1
// RL7 - software reset leaves this register unchanged
// RL8 - bits 15..12 read/write by host, the rest read-only
// RL9 - fetched config with bit 15 set raises programmable interrupt
// RL10 - software toggles the interrupt bit on alternate descriptors
// RL11 - bit 14 picks late-collision timer start: SFD or first preamble
// RL12 - bit 13 zero appends 4-byte FCS, one omits it
// RL13 - bit 12 zero enables, one disables excessive-deferral timer
// RL14 - deferring 3.2 ms with timer enabled sets bit 10 and aborts
// RL15 - reserved bits 11 and 4 read zero; software writes zero
// RL16 - bit 9 set on first-attempt deferral, reset on later collisions
// RL17 - sixteen collisions set bit 6 and abort
// RL18 - bit 8 set at preamble start, reset when carrier is seen; the code sets it at tx_start, not on the preamble event
// RL19 - collision over 51.2 us after timer start sets bit 5
`timescale 1ns/1ps
`default_nettype none
module etc_tx_ctrl #(
    parameter int DEFER_CYCLES = etc_pkg::DEFER_CYC,
    parameter int LATE_CYCLES  = etc_pkg::LATE_CYC
) (
    // clock, reset, enable
    input  wire logic                sys_clk_i,
    input  wire logic                resetn_i,
    input  wire logic                clk_en_i,
    // APB slave
    input  wire logic                psel_i,
    input  wire logic                penable_i,
    input  wire logic                pwrite_i,
    input  wire logic [11:0]         paddr_i,
    input  wire logic [31:0]         pwdata_i,
    output var  logic [31:0]         prdata_o,
    output logic                     pready_o,
    output logic                     pslverr_o,
    // MAC engine
    input  wire etc_pkg::etc_mac_ev_t mac_ev_i,
    output var  etc_pkg::etc_wb_t    wb_o,
    output var  logic                abort_o,
    output logic                     fcs_append_o,
    output logic                     late_timer_run_o,
    // interrupt
    output logic                     irq_o
);
    import etc_pkg::*;

    // =================================================================
    // APB decode
    logic acc;
    logic wr;
    logic hit_ctl;
    logic hit_ist;
    logic hit_imr;
    assign acc       = psel_i & penable_i & clk_en_i;
    assign wr        = acc & pwrite_i;
    assign hit_ctl   = paddr_i == CTL_ADDR;
    assign hit_ist   = paddr_i == IST_ADDR;
    assign hit_imr   = paddr_i == IMR_ADDR;
    assign pready_o  = psel_i & penable_i & clk_en_i;
    assign pslverr_o = pready_o & ~(hit_ctl | hit_ist | hit_imr);

    // =================================================================
    // transmit state
    logic [15:0] tcr_reg, tcr_next;
    logic [15:0] pend_reg, pend_next;
    logic [4:0]  coll_reg, coll_next;
    logic [19:0] dcnt_reg, dcnt_next;
    logic [13:0] lcnt_reg, lcnt_next;
    logic        act_reg, act_next;
    logic        lrun_reg, lrun_next;
    logic        abort_reg, abort_next;
    etc_wb_t     wb_reg, wb_next;
    logic        programmable_tx_interrupt_set;
    logic        late_hit;
    logic [15:0] merged;

    assign late_hit = lrun_reg &&
        (lcnt_reg >= 14'(LATE_CYCLES - 1));

    always_comb begin
        tcr_next   = tcr_reg;
        pend_next  = pend_reg;
        coll_next  = coll_reg;
        dcnt_next  = dcnt_reg;
        lcnt_next  = lcnt_reg;
        act_next   = act_reg;
        lrun_next  = lrun_reg;
        abort_next = 1'b0;
        wb_next    = '0;
        programmable_tx_interrupt_set   = 1'b0;
        merged     = tcr_reg | pend_reg;                         // [RL2]
        // these three report the last frame only
        merged[B_MBAD] = pend_reg[B_MBAD];
        merged[B_UND]  = pend_reg[B_UND];
        merged[B_TOK]  = pend_reg[B_TOK];
        // only the mode nibble takes host writes
        if (wr && hit_ctl) begin
            tcr_next[15:12] = pwdata_i[15:12];                   // [RL8]
        end
        if (act_reg) begin
            if (mac_ev_i.crs) begin
                tcr_next[B_NCAR] = 1'b0;                         // [RL18]
            end
            if (mac_ev_i.first_defer) begin
                tcr_next[B_DFR] = 1'b1;                          // [RL16]
            end
            pend_next[B_CLST] = pend_reg[B_CLST] | mac_ev_i.crs_lost;
            pend_next[B_MBAD] = pend_reg[B_MBAD] | mac_ev_i.mon_bad;
            pend_next[B_UND]  = pend_reg[B_UND] | mac_ev_i.underrun;
            pend_next[B_LMIS] = pend_reg[B_LMIS] | mac_ev_i.len_mismatch;
            pend_next[B_TOK]  = pend_reg[B_TOK] | mac_ev_i.tx_ok;
            if (mac_ev_i.collision) begin
                tcr_next[B_DFR] = 1'b0;                          // [RL16]
                if (coll_reg != 5'h1F) begin
                    coll_next = coll_reg + 5'h01;
                end
                if (coll_reg == 5'(COLL_MAX - 1)) begin
                    tcr_next[B_XCOL] = 1'b1;                     // [RL17]
                    abort_next      = 1'b1;
                end
                // late collision still backs off like a normal one
                if (late_hit) begin
                    pend_next[B_OWC] = 1'b1;                     // [RL19]
                end
            end
            // timer start point follows the mode bit
            if ((mac_ev_i.preamble && tcr_reg[B_LTS]) ||
                (mac_ev_i.sfd && !tcr_reg[B_LTS])) begin         // [RL11]
                lrun_next = 1'b1;
                lcnt_next = '0;
            end else if (lrun_reg && !late_hit) begin
                lcnt_next = lcnt_reg + 14'h0001;
            end
            if (mac_ev_i.deferring && !tcr_reg[B_EXDS]) begin    // [RL13]
                dcnt_next = dcnt_reg + 20'h00001;
                if (dcnt_reg == 20'(DEFER_CYCLES - 1)) begin
                    tcr_next[B_XDF] = 1'b1;                      // [RL14]
                    abort_next      = 1'b1;
                end
            end else begin
                dcnt_next = '0;
            end
        end
        if (mac_ev_i.tx_end && act_reg) begin
            tcr_next[10:0] = merged[10:0];                       // [RL2]
            wb_next.valid  = 1'b1;                               // [RL3]
            wb_next.status = merged;
            wb_next.coll   = coll_reg;
            act_next       = 1'b0;
            lrun_next      = 1'b0;
            pend_next      = '0;
        end
        if (mac_ev_i.wb_done) begin
            tcr_next[B_DFR] = 1'b0;                              // [RL4]
            tcr_next[B_OWC] = 1'b0;                              // [RL4]
        end
        // a new frame overrides the mode nibble, bits 10, 8, 7, 6 and 1, the counters and pending flags in its cycle
        if (mac_ev_i.tx_start) begin
            programmable_tx_interrupt_set = mac_ev_i.cfg_hi[3] & ~tcr_reg[B_PGI];     // [RL9]
            tcr_next[15:12]  = mac_ev_i.cfg_hi;                  // [RL1]
            tcr_next[B_XDF]  = 1'b0;                             // [RL5]
            tcr_next[B_CLST] = 1'b0;
            tcr_next[B_XCOL] = 1'b0;
            tcr_next[B_LMIS] = 1'b0;
            tcr_next[B_NCAR] = 1'b1;                             // [RL18]
            act_next  = 1'b1;
            coll_next = '0;
            dcnt_next = '0;
            lcnt_next = '0;
            lrun_next = 1'b0;
            pend_next = '0;
        end
        tcr_next[B_RSV1] = 1'b0;                                 // [RL15]
        tcr_next[B_RSV0] = 1'b0;                                 // [RL15]
    end

    // no software-reset input: that command must not touch this state
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin     // [RL7]
        if (!resetn_i) begin
            tcr_reg   <= CTL_RST;                                // [RL6]
            pend_reg  <= '0;
            coll_reg  <= '0;
            dcnt_reg  <= '0;
            lcnt_reg  <= '0;
            act_reg   <= 1'b0;
            lrun_reg  <= 1'b0;
            abort_reg <= 1'b0;
            wb_reg    <= '0;
        end else if (clk_en_i) begin
            tcr_reg   <= tcr_next;
            pend_reg  <= pend_next;
            coll_reg  <= coll_next;
            dcnt_reg  <= dcnt_next;
            lcnt_reg  <= lcnt_next;
            act_reg   <= act_next;
            lrun_reg  <= lrun_next;
            abort_reg <= abort_next;
            wb_reg    <= wb_next;
        end
    end

    assign wb_o             = wb_reg;
    assign abort_o          = abort_reg;
    assign fcs_append_o     = ~tcr_reg[B_FCSI];                  // [RL12]
    assign late_timer_run_o = lrun_reg;

    // =================================================================
    // interrupts and read data
    logic [IRQ_W-1:0] ist_reg, ist_next;
    logic [IRQ_W-1:0] imk_reg, imk_next;
    logic [31:0]      rd_reg, rd_next;
    logic [IRQ_W-1:0] ev_set;

    assign ev_set = {abort_next, wb_next.valid, programmable_tx_interrupt_set};

    always_comb begin
        ist_next = ist_reg;
        imk_next = imk_reg;
        rd_next  = rd_reg;
        // the clear on read loses to a same-cycle event
        if (acc && !pwrite_i && hit_ist) begin
            ist_next = '0;
        end
        ist_next = ist_next | ev_set;
        if (wr && hit_imr) begin
            imk_next = pwdata_i[IRQ_W-1:0];
        end
        // sampled in setup so the access phase needs no wait state
        if (psel_i && !penable_i) begin
            rd_next = '0;
            if (hit_ctl) begin
                rd_next[15:0] = tcr_reg;
            end else if (hit_ist) begin
                rd_next[IRQ_W-1:0] = ist_reg;
            end else if (hit_imr) begin
                rd_next[IRQ_W-1:0] = imk_reg;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ist_reg <= '0;
            imk_reg <= '0;
            rd_reg  <= '0;
        end else if (clk_en_i) begin
            ist_reg <= ist_next;
            imk_reg <= imk_next;
            rd_reg  <= rd_next;
        end
    end

    assign prdata_o = rd_reg;
    assign irq_o    = |(ist_reg & imk_reg);

    // =================================================================
    // checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    sequence start_s;
        clk_en_i && mac_ev_i.tx_start;
    endsequence

    load_modes_a: assert property (                              // [RL1]
        start_s |=> tcr_reg[15:12] == $past(mac_ev_i.cfg_hi))
        else $error("mode nibble not loaded at start");

    start_clear_a: assert property (                             // [RL5]
        start_s |=> tcr_reg[B_NCAR] && !tcr_reg[B_XDF] &&
            !tcr_reg[B_CLST] && !tcr_reg[B_XCOL] && !tcr_reg[B_LMIS])
        else $error("status bits not renewed at start");

    wb_clear_a: assert property (                                // [RL4]
        clk_en_i && mac_ev_i.wb_done && !mac_ev_i.tx_end
            |=> !tcr_reg[B_DFR] && !tcr_reg[B_OWC])
        else $error("bits 9 and 5 survive write-back");

    wb_pulse_a: assert property (                                // [RL3]
        clk_en_i && mac_ev_i.tx_end && act_reg && !mac_ev_i.tx_start
            |=> wb_o.valid && wb_o.status[10:0] == tcr_reg[10:0]
            ##1 clk_en_i [*1] ##0 !wb_o.valid)
        else $error("status write-back wrong");

    ro_bits_a: assert property (                                 // [RL8]
        clk_en_i && wr && hit_ctl && !act_reg && mac_ev_i == '0
            |=> $stable(tcr_reg[11:0]))
        else $error("host write reached read-only bits");

    programmable_tx_interrupt_irq_a: assert property (                                // [RL9]
        start_s ##0 (mac_ev_i.cfg_hi[3] && !tcr_reg[B_PGI])
            |=> ist_reg[IRQ_PGI])
        else $error("programmable interrupt not raised");

    defer_off_a: assert property (                               // [RL14]
        $rose(tcr_reg[B_XDF]) |-> !$past(tcr_reg[B_EXDS]) &&
            $past(abort_next))
        else $error("deferral flag with timer off");

    reserved_a: assert property (                                // [RL15]
        !tcr_reg[B_RSV1] && !tcr_reg[B_RSV0])
        else $error("reserved bit set");

    excess_coll_a: assert property (                             // [RL17]
        clk_en_i && act_reg && mac_ev_i.collision &&
            coll_reg == 5'(COLL_MAX - 1) && !mac_ev_i.tx_start
            |=> tcr_reg[B_XCOL] && abort_o)
        else $error("sixteenth collision not flagged");

    no_carrier_a: assert property (                              // [RL18]
        clk_en_i && act_reg && mac_ev_i.crs && !mac_ev_i.tx_start
            |=> !tcr_reg[B_NCAR])
        else $error("carrier seen but bit 8 stays");

endmodule // etc_tx_ctrl
`default_nettype wire

// >>> test/ethernet_tx_control_status_tb_top.sv
/*
 * self-checking bench for the transmit control and status bank:
 * APB register access, frame start/end updates, timers and interrupts.
 * assumes etc_pkg and etc_tx_ctrl are compiled first; one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module ethernet_tx_control_status_tb_top;
    import etc_pkg::*;
    // =================================================================
    // stimulus and observation
    // short timer counts keep the run brief; expectations follow them
    localparam int DEF_C  = 50;
    localparam int LATE_C = 20;
    logic        sys_clk = 1'b0;
    logic        resetn  = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    etc_mac_ev_t ev_p    = '0;
    etc_mac_ev_t ev_l    = '0;
    etc_mac_ev_t mac_ev;
    etc_wb_t     wb;
    etc_wb_t     wb_cap;
    logic        abort;
    logic        fcs_o;
    logic        late_run;
    logic        irq;
    int          n_wb    = 0;
    int          n_abort = 0;
    int          n_fail  = 0;
    int          total_checks = 0;

    assign mac_ev = ev_p | ev_l;
    always #2.5 sys_clk = ~sys_clk;

    etc_tx_ctrl #(
        .DEFER_CYCLES (DEF_C),
        .LATE_CYCLES  (LATE_C)
    ) i_etc_tx_ctrl (
        .sys_clk_i        (sys_clk),
        .resetn_i         (resetn),
        .clk_en_i         (1'b1),
        .psel_i           (psel),
        .penable_i        (penable),
        .pwrite_i         (pwrite),
        .paddr_i          (paddr),
        .pwdata_i         (pwdata),
        .prdata_o         (prdata),
        .pready_o         (pready),
        .pslverr_o        (pslverr),
        .mac_ev_i         (mac_ev),
        .wb_o             (wb),
        .abort_o          (abort),
        .fcs_append_o     (fcs_o),
        .late_timer_run_o (late_run),
        .irq_o            (irq)
    );

    // single-cycle outputs are caught here so no pulse is missed
    always @(posedge sys_clk) begin
        if (wb.valid === 1'b1) begin
            n_wb   <= n_wb + 1;
            wb_cap <= wb;
        end
        if (abort === 1'b1) begin
            n_abort <= n_abort + 1;
        end
    end

    // =================================================================
    // checking and bus tasks
    task automatic chk_word(input logic [31:0] g, input logic [31:0] x);
        total_checks++;
        if (g !== x) begin
            n_fail++;
            $display("unexpected at %0t: word %h, wanted %h", $time, g, x);
        end
    endtask

    task automatic chk_bit(input logic g, input logic x);
        total_checks++;
        if (g !== x) begin
            n_fail++;
            $display("unexpected at %0t: bit %b, wanted %b", $time, g, x);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge sys_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        chk_word(q, x);
    endtask

    task automatic pulse(input etc_mac_ev_t e);
        @(posedge sys_clk);
        ev_p <= e;
        @(posedge sys_clk);
        ev_p <= '0;
    endtask

    // ends the frame and compares the descriptor status write-back
    task automatic end_frame(input logic [15:0] st, input logic [4:0] nc);
        int n0;
        n0 = n_wb;
        pulse('{tx_end: 1'b1, default: '0});
        repeat (4) if (n_wb == n0) @(posedge sys_clk);
        chk_bit(n_wb == n0 + 1, 1'b1);
        chk_word({16'h0000, wb_cap.status}, {16'h0000, st});
        chk_word({27'h0000000, wb_cap.coll}, {27'h0000000, nc});
    endtask

    task automatic summarize;
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // =================================================================
    // tests
    initial begin
        logic [31:0] q;
        logic        e;
        logic        b;
        int          n0;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(CTL_ADDR, 32'h0000_0101);
        rd(IST_ADDR, 32'h0000_0000);
        wr(CTL_ADDR, 32'hFFFF_FFFF);
        rd(CTL_ADDR, 32'h0000_F101);
        @(negedge sys_clk);
        chk_bit(fcs_o, 1'b0);
        wr(CTL_ADDR, 32'h0000_0000);
        @(negedge sys_clk);
        chk_bit(fcs_o, 1'b1);
        apb(1'b0, 12'h0F0, 32'h0000_0000, q, e);
        chk_bit(e, 1'b1);
        chk_word(q, 32'h0000_0000);
        wr(IMR_ADDR, 32'h0000_0007);
        // frame one: interrupt requested, deferred, carrier seen, good
        pulse('{tx_start: 1'b1, cfg_hi: 4'h8, default: '0});
        rd(CTL_ADDR, 32'h0000_8101);
        chk_bit(irq, 1'b1);
        pulse('{first_defer: 1'b1, default: '0});
        pulse('{preamble: 1'b1, default: '0});
        @(negedge sys_clk);
        chk_bit(late_run, 1'b0);
        pulse('{sfd: 1'b1, default: '0});
        @(negedge sys_clk);
        chk_bit(late_run, 1'b1);
        ev_l.crs <= 1'b1;
        pulse('{tx_ok: 1'b1, default: '0});
        end_frame(16'h8201, 5'd0);
        ev_l.crs <= 1'b0;
        rd(IST_ADDR, 32'h0000_0003);
        rd(IST_ADDR, 32'h0000_0000);
        @(negedge sys_clk);
        chk_bit(irq, 1'b0);
        pulse('{wb_done: 1'b1, default: '0});
        rd(CTL_ADDR, 32'h0000_8001);
        // frame two: timer from preamble, sixteen collisions, the last seven late
        pulse('{tx_start: 1'b1, cfg_hi: 4'h4, default: '0});
        rd(CTL_ADDR, 32'h0000_4101);
        pulse('{preamble: 1'b1, default: '0});
        @(negedge sys_clk);
        chk_bit(late_run, 1'b1);
        repeat (16) pulse('{collision: 1'b1, default: '0});
        end_frame(16'h4160, 5'd16);
        chk_word(32'(n_abort), 32'd1);
        rd(IST_ADDR, 32'h0000_0006);
        pulse('{wb_done: 1'b1, default: '0});
        rd(CTL_ADDR, 32'h0000_4140);
        // frames three and four: deferral timer enabled, then disabled
        for (int i = 0; i < 2; i++) begin
            b  = (i == 0);
            n0 = n_abort;
            wr(IMR_ADDR, b ? 32'h0000_0007 : 32'h0000_0000);
            pulse('{tx_start: 1'b1, cfg_hi: 4'(i), default: '0});
            rd(CTL_ADDR, {16'h0000, 4'(i), 12'h100});
            ev_l.deferring <= 1'b1;
            repeat (DEF_C + 10) @(posedge sys_clk);
            ev_l.deferring <= 1'b0;
            chk_word(32'(n_abort - n0), {31'h0, b});
            end_frame({4'(i), 1'b0, b, 10'h100}, 5'd0);
            @(negedge sys_clk);
            chk_bit(irq, b);
            rd(IST_ADDR, {29'h0, b, 2'b10});
            pulse('{wb_done: 1'b1, default: '0});
        end
        summarize();
    end

    // a hang costs far more than the few hundred cycles the tests take
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        $display("unexpected at %0t: watchdog expired", $time);
        summarize();
    end
endmodule // ethernet_tx_control_status_tb_top
`default_nettype wire
